// >>> design/xb_consts.svh
`ifndef XB_CONSTS_SVH
`define XB_CONSTS_SVH
// Summary of operation
// R1: FIFO access drives word address and write strobe
// R2: Glueless FIFO reads only in space three
// R3: FIFO outputs change on FIFO clock rising edges
// R4: Read strobe lasts programmed count unless extended
// R5: Read selects lead strobe by setup, trail by hold
// R6: Write strobe lasts programmed count unless extended
// R7: Write selects and data obey write setup/hold
// R8: Read data captured at strobe trailing edge
// R9: Counts come from each space's own settings
// R10: Setup plus strobe at least four for ready
// R11: Ready input passes through internal synchroniser
// R12: Ready sampled three cycles before strobe end
// R13: Strobe ends three to four cycles after ready
// R14: Peripheral holds ready high two cycles minimum
// R15: Space select may linger after cycle ends
// R16: Ready is active high for peripheral accesses
// R17: Peripheral access uses word address and strobe
// R18: Host accesses use shared pins as byte enables
// R19: Host port ready is active low output
// R20: Direction and burst-last polarity latched at boot
// R21: Host presents its signals stable around clock edges
// R22: Host ready released a few cycles after edge
// R23: Phases are down-counters loaded per space

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define XB_CPU_PERIOD_NS   50
`define XB_RDY_SAMPLE_CYC  3
`define XB_RDY_RESUME_CYC  2
`define XB_EXT_SUM_MIN     4
`define XB_HOST_HOLD_NS    200
`define XB_HOST_HOLD_CYC   ((`XB_HOST_HOLD_NS + `XB_CPU_PERIOD_NS - 1) / `XB_CPU_PERIOD_NS)

// ----------------------------------------------------------------
// Spaces and reset values
// ----------------------------------------------------------------
`define XB_FIFO_READ_SPACE 3
`define XB_SPACES          4
`define XB_SEL_IDLE        4'hF
`endif

// >>> design/xb_pkg.sv
package xb_pkg;
	// Access engine states, Gray along setup-strobe-hold
	typedef enum logic [2:0] {
		XB_IDLE   = 3'h0,
		XB_SETUP  = 3'h1,
		XB_STROBE = 3'h3,
		XB_HOLD   = 3'h2,
		XB_WAIT   = 3'h7,
		XB_FIFO   = 3'h4,
		XB_HOST   = 3'h6
	} xb_state_t;

	// Host port beat states
	typedef enum logic [1:0] {
		XB_H_IDLE = 2'h0,
		XB_H_WAIT = 2'h1,
		XB_H_RDY  = 2'h3
	} xb_hstate_t;
endpackage : xb_pkg

// >>> design/xb_sync.sv
`timescale 1ns/1ns
`default_nettype none
module xb_sync #(
	parameter int W = 1
) (
	// Clock and level in
	input  wire logic         clock,
	input  wire logic [W-1:0] d,
	// Synchronised level
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;  // First stage, read only by q

	// ----------------------------------------------------------------
	// Two flip-flop synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule : xb_sync
`default_nettype wire

// >>> design/xb_host.sv
`timescale 1ns/1ns
`default_nettype none
module xb_host
	import xb_pkg::*;
(
	// Host clock domain
	input  wire logic        host_clock_in,
	input  wire logic        host_rst_n,
	// Boot polarities from the CPU domain
	input  wire logic        dir_pol,
	input  wire logic        blast_pol,
	// Host link inputs
	input  wire logic        host_chip_select_n,
	input  wire logic        host_address_strobe,
	input  wire logic        host_control_select,
	input  wire logic        host_direction,
	input  wire logic        host_burst_last,
	input  wire logic [3:0]  be_in,
	input  wire logic [31:0] data_in,
	// Handshake with the CPU domain
	input  wire logic        ack_tgl,
	output logic             req_tgl_r,
	output logic             cmd_write_r,
	output logic             cmd_ctrl_r,
	output logic [3:0]       cmd_be_r,
	output logic [31:0]      cmd_wdata_r,
	// Ready pin, active low
	output logic             ready_out_r,
	output logic             ready_oe_n_r
);
	xb_hstate_t  st_r;        // Beat state
	logic        burst_r;     // Inside a burst
	logic        last_r;      // Current beat is the last
	logic        ack_seen_r;  // Last answered toggle
	logic [2:0]  sy;          // Synced ack and polarities

	xb_sync #(.W(3)) u_sy (.clock(host_clock_in), .d({ack_tgl, dir_pol, blast_pol}), .q(sy));

	// Beat taken on chip select with strobe or burst
	wire take     = !host_chip_select_n && (host_address_strobe || burst_r);
	// Boot polarity applied to direction and last
	wire is_write = host_direction ^ sy[1];      // [R20]
	wire is_last  = host_burst_last ^ sy[0];     // [R20]
	wire acked    = sy[2] != ack_seen_r;

	// ----------------------------------------------------------------
	// Beat sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge host_clock_in) begin
		if (!host_rst_n) begin
			st_r <= XB_H_IDLE;
			burst_r <= 1'b0;
			last_r <= 1'b0;
			ack_seen_r <= 1'b0;
			req_tgl_r <= 1'b0;
			cmd_write_r <= 1'b0;
			cmd_ctrl_r <= 1'b0;
			cmd_be_r <= 4'h0;
			cmd_wdata_r <= 32'h0;
			ready_out_r <= 1'b1;
			ready_oe_n_r <= 1'b1;
		end else begin
			unique case (st_r)
				XB_H_IDLE: if (take) begin
					cmd_write_r <= is_write;
					cmd_ctrl_r <= host_control_select;
					cmd_be_r <= be_in;                       // [R18]
					cmd_wdata_r <= data_in;
					last_r <= is_last;
					burst_r <= 1'b1;
					req_tgl_r <= ~req_tgl_r;
					ready_oe_n_r <= 1'b0;                    // Drive not-ready
					ready_out_r <= 1'b1;
					st_r <= XB_H_WAIT;
				end
				XB_H_WAIT: if (acked) begin
					ack_seen_r <= sy[2];
					ready_out_r <= 1'b0;                     // [R19]
					st_r <= XB_H_RDY;
				end
				XB_H_RDY: begin
					ready_out_r <= 1'b1;
					ready_oe_n_r <= 1'b1;                    // [R22]
					burst_r <= !last_r;
					st_r <= XB_H_IDLE;
				end
			endcase
		end
	end
endmodule : xb_host
`default_nettype wire

// >>> design/xb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "xb_consts.svh"
module xb_top
	import xb_pkg::*;
#(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Access request
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire logic                 req_fifo,
	input  wire logic [1:0]           req_space,
	input  wire logic [3:0]           req_addr,
	input  wire logic [31:0]          req_wdata,
	// Per-space timing counts
	input  wire logic [4*CNT_W-1:0]   read_setup_count,
	input  wire logic [4*CNT_W-1:0]   read_strobe_count,
	input  wire logic [4*CNT_W-1:0]   read_hold_count,
	input  wire logic [4*CNT_W-1:0]   write_setup_count,
	input  wire logic [4*CNT_W-1:0]   write_strobe_count,
	input  wire logic [4*CNT_W-1:0]   write_hold_count,
	// Access answer
	output logic                      busy,
	output logic                      rd_valid,
	output logic [31:0]               rd_data,
	output logic                      req_refused,
	// Boot straps
	input  wire logic                 strap_dir_pol,
	input  wire logic                 strap_blast_pol,
	// Host beats to the user
	output logic                      host_req_valid,
	output logic                      host_req_write,
	output logic                      host_req_ctrl,
	output logic [3:0]                host_req_be,
	output logic [31:0]               host_req_wdata,
	input  wire logic                 host_resp_valid,
	input  wire logic [31:0]          host_resp_rdata,
	// Expansion bus pins
	output logic                      fifo_clock_out,
	output logic [3:0]                space_select_n,
	input  wire logic [3:0]           byte_enable_or_word_addr_in,
	output logic [3:0]                byte_enable_or_word_addr_out,
	output logic                      byte_enable_or_word_addr_oe_n,
	output logic                      output_enable_n,
	output logic                      read_strobe_n,
	output logic                      write_strobe_or_wait,
	input  wire logic [31:0]          expansion_data_bus_in,
	output logic [31:0]               expansion_data_bus_out,
	output logic                      expansion_data_bus_oe_n,
	input  wire logic                 ready_line_in,
	output logic                      ready_line_out,
	output logic                      ready_line_oe_n,
	// Host link
	input  wire logic                 host_clock_in,
	input  wire logic                 host_chip_select_n,
	input  wire logic                 host_address_strobe,
	input  wire logic                 host_control_select,
	input  wire logic                 host_direction,
	input  wire logic                 host_burst_last
);
	localparam logic [CNT_W-1:0] ONE   = CNT_W'(1);
	localparam logic [CNT_W-1:0] SAMP  = CNT_W'(`XB_RDY_SAMPLE_CYC);
	localparam logic [CNT_W-1:0] RESUM = CNT_W'(`XB_RDY_RESUME_CYC);
	localparam logic [CNT_W:0]   SUMIN = (CNT_W+1)'(`XB_EXT_SUM_MIN);
	localparam logic [2:0]       HHOLD = 3'(`XB_HOST_HOLD_CYC);

	// ----------------------------------------------------------------
	// Count selection
	// ----------------------------------------------------------------
	// Pick one space's count; zero is taken as one
	function automatic logic [CNT_W-1:0] pick(input logic [4*CNT_W-1:0] f, input logic [1:0] sp);
		logic [CNT_W-1:0] v;
		v = f[sp*CNT_W +: CNT_W];
		pick = (v == '0) ? ONE : v;
	endfunction : pick

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	xb_state_t         st_r, st_nxt;             // Engine state
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;           // Phase down-counter
	logic              pend_r, pend_nxt;         // Request waiting to launch
	logic              wr_r, wr_nxt;             // Latched direction
	logic              fifo_r, fifo_nxt;         // Latched FIFO mode
	logic [1:0]        sp_r, sp_nxt;             // Latched space
	logic [3:0]        addr_r, addr_nxt;         // Latched word address
	logic [31:0]       wd_r, wd_nxt;             // Latched write data
	logic              fclk_r;                   // FIFO clock divider
	logic [31:0]       cap_r, cap_nxt;           // First read capture
	logic              cpend_r, cpend_nxt;       // Capture waiting
	logic              dir_pol_r, blast_pol_r;   // Boot polarities
	logic              ack_r, ack_nxt;           // Host answer toggle
	logic              hseen_r, hseen_nxt;       // Last host toggle seen
	logic [2:0]        hh_r, hh_nxt;             // Host data drive count
	logic              hrst_n;                   // Host domain reset
	logic [1:0]        ps;                       // Synced straps
	logic [1:0]        cs;                       // Synced ready and host toggle
	logic              h_req_tgl;                // Host request toggle
	logic              h_write, h_ctrl;          // Host command bits
	logic [3:0]        h_be;                     // Host byte enables
	logic [31:0]       h_wd;                     // Host write data
	logic [3:0]        sel_nxt;                  // Space select next
	logic              be_oe_nxt, oe_nxt, rs_nxt, ws_nxt, doe_nxt;
	logic [31:0]       dout_nxt;
	logic              busy_nxt, rdv_nxt, ref_nxt, hrv_nxt;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	xb_sync #(.W(2)) u_cs (.clock(clock), .d({ready_line_in, h_req_tgl}), .q(cs));  // [R11]
	xb_sync #(.W(2)) u_ps (.clock(clock), .d({strap_dir_pol, strap_blast_pol}), .q(ps));
	xb_sync #(.W(1)) u_hr (.clock(host_clock_in), .d(rst_n), .q(hrst_n));

	// ----------------------------------------------------------------
	// Host clock domain beat handler
	// ----------------------------------------------------------------
	xb_host u_host (
		.host_clock_in       (host_clock_in),
		.host_rst_n          (hrst_n),
		.dir_pol             (dir_pol_r),
		.blast_pol           (blast_pol_r),
		.host_chip_select_n  (host_chip_select_n),
		.host_address_strobe (host_address_strobe),
		.host_control_select (host_control_select),
		.host_direction      (host_direction),
		.host_burst_last     (host_burst_last),
		.be_in               (byte_enable_or_word_addr_in),
		.data_in             (expansion_data_bus_in),
		.ack_tgl             (ack_r),
		.req_tgl_r           (h_req_tgl),
		.cmd_write_r         (h_write),
		.cmd_ctrl_r          (h_ctrl),
		.cmd_be_r            (h_be),
		.cmd_wdata_r         (h_wd),
		.ready_out_r         (ready_line_out),
		.ready_oe_n_r        (ready_line_oe_n)
	);

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire              rdy_s    = cs[1];                                        // [R16]
	wire              host_new = cs[0] != hseen_r;
	wire [CNT_W-1:0]  setup_c  = wr_r ? pick(write_setup_count, sp_r) : pick(read_setup_count, sp_r);   // [R9]
	wire [CNT_W-1:0]  strobe_c = wr_r ? pick(write_strobe_count, sp_r) : pick(read_strobe_count, sp_r);
	wire [CNT_W-1:0]  hold_c   = wr_r ? pick(write_hold_count, sp_r) : pick(read_hold_count, sp_r);
	wire [CNT_W:0]    ext_sum  = {1'b0, setup_c} + {1'b0, strobe_c};
	wire              ext_ok   = ext_sum >= SUMIN;                             // [R10]
	wire              fifo_rd_bad = !wr_r && (sp_r != 2'(`XB_FIFO_READ_SPACE));  // [R2]
	wire [3:0]        sel_dec  = ~(4'h1 << sp_r);
	wire              fifo_edge = !fclk_r;                                     // Next edge raises FIFO clock

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		pend_nxt = pend_r;
		wr_nxt = wr_r;
		fifo_nxt = fifo_r;
		sp_nxt = sp_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		cap_nxt = cap_r;
		cpend_nxt = 1'b0;
		ack_nxt = ack_r;
		hseen_nxt = hseen_r;
		hh_nxt = hh_r;
		sel_nxt = space_select_n;
		be_oe_nxt = byte_enable_or_word_addr_oe_n;
		oe_nxt = output_enable_n;
		rs_nxt = read_strobe_n;
		ws_nxt = write_strobe_or_wait;
		doe_nxt = expansion_data_bus_oe_n;
		dout_nxt = expansion_data_bus_out;
		busy_nxt = busy;
		rdv_nxt = cpend_r;
		ref_nxt = 1'b0;
		hrv_nxt = 1'b0;
		// Host read data released after a fixed drive time
		if (hh_r != 3'h0) begin
			hh_nxt = hh_r - 3'h1;
			if (hh_r == 3'h1)
				doe_nxt = 1'b1;
		end
		unique case (st_r)
			XB_IDLE: begin
				if (pend_r) begin
					if (fifo_r && fifo_rd_bad) begin
						pend_nxt = 1'b0;                      // Refused read
						busy_nxt = 1'b0;
						ref_nxt = 1'b1;
					end else if (fifo_r && fifo_edge) begin
						pend_nxt = 1'b0;                      // [R3]
						sel_nxt = sel_dec;
						addr_nxt = addr_r;
						be_oe_nxt = 1'b0;                     // [R1]
						oe_nxt = wr_r;
						rs_nxt = wr_r;
						ws_nxt = !wr_r;                       // [R1]
						doe_nxt = !wr_r;
						dout_nxt = wd_r;
						hh_nxt = 3'h0;
						st_nxt = XB_FIFO;
					end else if (!fifo_r) begin
						pend_nxt = 1'b0;                      // [R17]
						sel_nxt = sel_dec;
						be_oe_nxt = 1'b0;
						oe_nxt = wr_r;                        // [R5]
						doe_nxt = !wr_r;                      // [R7]
						dout_nxt = wd_r;
						hh_nxt = 3'h0;
						cnt_nxt = setup_c;                    // [R23]
						st_nxt = XB_SETUP;
					end
				end else if (req_valid) begin
					pend_nxt = 1'b1;
					busy_nxt = 1'b1;
					wr_nxt = req_write;
					fifo_nxt = req_fifo;
					sp_nxt = req_space;
					addr_nxt = req_addr;
					wd_nxt = req_wdata;
				end else if (host_new) begin
					hseen_nxt = cs[0];
					busy_nxt = 1'b1;
					hrv_nxt = 1'b1;
					be_oe_nxt = 1'b1;                         // [R18]
					st_nxt = XB_HOST;
				end
			end
			XB_SETUP: begin
				if (cnt_r == ONE) begin
					cnt_nxt = strobe_c;                       // [R23]
					rs_nxt = wr_r;                            // [R4]
					ws_nxt = !wr_r;                           // [R6]
					st_nxt = XB_STROBE;
				end else
					cnt_nxt = cnt_r - ONE;                    // [R5] [R7]
			end
			XB_STROBE: begin
				if (cnt_r == SAMP && ext_ok && !rdy_s)
					st_nxt = XB_WAIT;                         // [R12]
				else if (cnt_r == ONE) begin
					rs_nxt = 1'b1;
					ws_nxt = 1'b1;
					if (!wr_r) begin
						cap_nxt = expansion_data_bus_in;      // [R8]
						cpend_nxt = 1'b1;
					end
					cnt_nxt = hold_c;                         // [R23]
					st_nxt = XB_HOLD;
				end else
					cnt_nxt = cnt_r - ONE;                    // [R4] [R6]
			end
			XB_WAIT: begin
				if (rdy_s) begin
					cnt_nxt = RESUM;                          // [R13]
					st_nxt = XB_STROBE;
				end
			end
			XB_HOLD: begin
				if (cnt_r == ONE) begin
					sel_nxt = `XB_SEL_IDLE;                   // [R15]
					be_oe_nxt = 1'b1;
					oe_nxt = 1'b1;
					doe_nxt = 1'b1;
					busy_nxt = 1'b0;
					st_nxt = XB_IDLE;
				end else
					cnt_nxt = cnt_r - ONE;                    // [R5] [R7]
			end
			XB_FIFO: begin
				if (fifo_edge) begin
					sel_nxt = `XB_SEL_IDLE;                   // [R3]
					be_oe_nxt = 1'b1;
					oe_nxt = 1'b1;
					rs_nxt = 1'b1;
					ws_nxt = 1'b1;
					doe_nxt = 1'b1;
					if (!wr_r) begin
						cap_nxt = expansion_data_bus_in;
						cpend_nxt = 1'b1;
					end
					busy_nxt = 1'b0;
					st_nxt = XB_IDLE;
				end
			end
			XB_HOST: begin
				if (host_resp_valid) begin
					if (!h_write) begin
						dout_nxt = host_resp_rdata;
						doe_nxt = 1'b0;
						hh_nxt = HHOLD;
					end
					ack_nxt = ~ack_r;
					busy_nxt = 1'b0;
					st_nxt = XB_IDLE;
				end
			end
			default: st_nxt = XB_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Boot polarity capture while reset is held
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dir_pol_r <= ps[1];                               // [R20]
			blast_pol_r <= ps[0];
		end
	end

	// ----------------------------------------------------------------
	// Engine state
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= XB_IDLE;
			cnt_r <= '0;
			pend_r <= 1'b0;
			cpend_r <= 1'b0;
			ack_r <= 1'b0;
			hseen_r <= 1'b0;
			hh_r <= 3'h0;
			fclk_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			pend_r <= pend_nxt;
			cpend_r <= cpend_nxt;
			ack_r <= ack_nxt;
			hseen_r <= hseen_nxt;
			hh_r <= hh_nxt;
			fclk_r <= ~fclk_r;
		end
	end

	// ----------------------------------------------------------------
	// Latched command and capture
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		wr_r <= wr_nxt;
		fifo_r <= fifo_nxt;
		sp_r <= sp_nxt;
		addr_r <= addr_nxt;
		wd_r <= wd_nxt;
		cap_r <= cap_nxt;
	end

	// ----------------------------------------------------------------
	// Pin and answer outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			space_select_n <= `XB_SEL_IDLE;
			byte_enable_or_word_addr_out <= 4'h0;
			byte_enable_or_word_addr_oe_n <= 1'b1;
			output_enable_n <= 1'b1;
			read_strobe_n <= 1'b1;
			write_strobe_or_wait <= 1'b1;
			expansion_data_bus_out <= 32'h0;
			expansion_data_bus_oe_n <= 1'b1;
			busy <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 32'h0;
			req_refused <= 1'b0;
			host_req_valid <= 1'b0;
			host_req_write <= 1'b0;
			host_req_ctrl <= 1'b0;
			host_req_be <= 4'h0;
			host_req_wdata <= 32'h0;
		end else begin
			space_select_n <= sel_nxt;
			byte_enable_or_word_addr_out <= addr_nxt;
			byte_enable_or_word_addr_oe_n <= be_oe_nxt;
			output_enable_n <= oe_nxt;
			read_strobe_n <= rs_nxt;
			write_strobe_or_wait <= ws_nxt;
			expansion_data_bus_out <= dout_nxt;
			expansion_data_bus_oe_n <= doe_nxt;
			busy <= busy_nxt;
			rd_valid <= rdv_nxt;
			if (cpend_r)
				rd_data <= cap_r;                             // [R8]
			req_refused <= ref_nxt;
			host_req_valid <= hrv_nxt;
			host_req_write <= h_write;
			host_req_ctrl <= h_ctrl;
			host_req_be <= h_be;
			host_req_wdata <= h_wd;
		end
	end

	assign fifo_clock_out = fclk_r;
endmodule : xb_top
`default_nettype wire

// >>> verif/xb_periph.sv
`timescale 1ns/1ns
`default_nettype none
module xb_periph (
	// Strobes from the device
	input wire logic        clock,
	input wire logic        strobe_n,
	input wire logic        oe_n,
	// Scenario control
	input wire logic [4:0]  stall,
	input wire logic [31:0] word,
	// Answers
	output logic            ready,
	output logic [31:0]     data
);
	logic [4:0] cnt_r; // Strobe-low cycles
	// Count strobe-low cycles, saturating
	always_ff @(posedge clock) begin
		if (strobe_n) cnt_r <= 5'h00;
		else if (cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
	end
	// Active-high ready, then high until next strobe
	assign ready = strobe_n || cnt_r >= stall;
	// Released bus shows the inverse word
	assign data = oe_n ? ~word : word;
endmodule : xb_periph
`default_nettype wire

// >>> verif/xb_checker.sv
`timescale 1ns/1ns
`default_nettype none
module xb_checker (
	// Request side
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       req_valid,
	input wire logic       req_write,
	input wire logic       req_fifo,
	input wire logic [1:0] req_space,
	input wire logic       busy,
	input wire logic       rd_valid,
	input wire logic       req_refused,
	// Bus pins
	input wire logic [3:0] space_select_n,
	input wire logic       output_enable_n,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_or_wait,
	input wire logic       expansion_data_bus_oe_n,
	input wire logic       fifo_clock_out,
	input wire logic       ready_line_in
);
	logic fifo_r; // Last accepted access was FIFO
	// Track access kind
	always_ff @(posedge clock) begin
		if (!rst_n) fifo_r <= 1'b0;
		else if (req_valid && !busy) fifo_r <= req_fifo;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_refuse; req_valid && !busy && req_fifo && !req_write && req_space != 2'h3 |-> ##[1:2] req_refused; endproperty
	a_refuse: assert property (p_refuse) else $error("no refusal");
	property p_fifo_edge; fifo_r && $changed(read_strobe_n) |-> $rose(fifo_clock_out); endproperty
	a_fifo_edge: assert property (p_fifo_edge) else $error("fifo off edge");
	property p_rd_setup; !fifo_r && $fell(read_strobe_n) |-> $past(output_enable_n) == 1'b0 && !(&space_select_n); endproperty
	a_rd_setup: assert property (p_rd_setup) else $error("no setup");
	property p_rd_hold; !fifo_r && $rose(read_strobe_n) |-> !output_enable_n; endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("no hold");
	property p_rd_valid; !fifo_r && $rose(read_strobe_n) |-> ##[1:2] rd_valid; endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("no data");
	property p_wr_data; busy && !write_strobe_or_wait |-> !expansion_data_bus_oe_n; endproperty
	a_wr_data: assert property (p_wr_data) else $error("data off");
	property p_ready_end; !fifo_r && !read_strobe_n && $rose(ready_line_in) |-> ##[1:5] read_strobe_n; endproperty
	a_ready_end: assert property (p_ready_end) else $error("strobe stuck");
	property p_idle; !busy |-> &space_select_n; endproperty
	a_idle: assert property (p_idle) else $error("select stuck");
	c_refuse: cover property (req_refused);
	c_fifo: cover property (fifo_r && $rose(fifo_clock_out));
	c_ready: cover property (!read_strobe_n && $rose(ready_line_in));
endmodule : xb_checker
bind xb_top xb_checker xb_checker_i (.*);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// Inputs
	logic clock = 0, rst_n = 0, host_clock_in = 0, req_valid = 0, req_write = 0, req_fifo = 0, hw = 0;
	logic host_resp_valid = 0, strap_dir_pol = 1, strap_blast_pol = 0, host_chip_select_n = 1;
	logic host_address_strobe = 0, host_control_select = 0, host_direction = 0, host_burst_last = 0;
	logic [1:0] req_space = 0;
	logic [3:0] req_addr = 0, hbe = 0;
	logic [31:0] req_wdata = 0, host_resp_rdata = 0, word = 0;
	logic [15:0] read_setup_count = 16'h4321, read_strobe_count = 16'h7654, read_hold_count = 16'h1232;
	logic [15:0] write_setup_count = 16'h2345, write_strobe_count = 16'h4567, write_hold_count = 16'h3121;
	logic [4:0] stall = 0;
	// Outputs
	logic busy, rd_valid, req_refused, host_req_valid, host_req_write, host_req_ctrl, fifo_clock_out, p_rdy;
	logic output_enable_n, read_strobe_n, write_strobe_or_wait, expansion_data_bus_oe_n;
	logic byte_enable_or_word_addr_oe_n, ready_line_out, ready_line_oe_n, w;
	logic [1:0] sp;
	logic [3:0] host_req_be, space_select_n, byte_enable_or_word_addr_out, av, a, es, ew, eh;
	logic [31:0] rd_data, host_req_wdata, expansion_data_bus_out, p_data, dv, d;
	wire logic ready_line_in;
	wire logic [3:0] byte_enable_or_word_addr_in;
	wire logic [31:0] expansion_data_bus_in;
	int errors = 0, compares = 0, ns, nw, nh, nref = 0, nrv = 0, i;
	// Write, space, address, setup/strobe/hold, data
	logic [50:0] rows [4] = '{
		{1'b0, 2'h0, 4'h5, 12'h142, 32'h1234_5678},
		{1'b1, 2'h1, 4'hA, 12'h462, 32'hA5A5_0001},
		{1'b0, 2'h2, 4'hF, 12'h362, 32'h8765_4321},
		{1'b1, 2'h3, 4'h0, 12'h243, 32'h0F0F_F0F0}};
	xb_top xb_top_i (.*);
	xb_periph xb_periph_i (.clock(clock), .strobe_n(read_strobe_n & write_strobe_or_wait),
		.oe_n(output_enable_n), .stall(stall), .word(word), .ready(p_rdy), .data(p_data));
	// Pin levels from all drivers
	assign ready_line_in = ready_line_oe_n ? p_rdy : ready_line_out;
	assign byte_enable_or_word_addr_in = byte_enable_or_word_addr_oe_n ? hbe : byte_enable_or_word_addr_out;
	assign expansion_data_bus_in = !expansion_data_bus_oe_n ? expansion_data_bus_out : (hw ? 32'hC0DE_0042 : p_data);
	always #25 clock = ~clock;
	always #15 host_clock_in = ~host_clock_in;
	// Count answer pulses
	always @(negedge clock) begin
		nref += (req_refused === 1'b1);
		nrv += (rd_valid === 1'b1);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		if (errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	// One access, measuring setup, strobe and hold cycles
	task automatic run(input logic wr, fi, input logic [1:0] s, input logic [3:0] ad, input logic [31:0] dt);
		ns = 0;
		nw = 0;
		nh = 0;
		@(posedge clock) #5;
		{req_valid, req_write, req_fifo, req_space, req_addr, req_wdata} = {1'b1, wr, fi, s, ad, dt};
		@(posedge clock) #5 req_valid = 0;
		for (i = 0; i < 300 && (busy !== 1'b0 || i < 3); i++) begin
			@(negedge clock);
			if (!(read_strobe_n & write_strobe_or_wait)) begin
				nw++;
				av = byte_enable_or_word_addr_out;
				dv = expansion_data_bus_out;
			end else if (space_select_n !== 4'hF) begin
				if (nw == 0) ns++;
				else nh++;
			end
		end
	endtask : run
	initial begin
		repeat (8) @(posedge clock);
		check({space_select_n, output_enable_n, read_strobe_n, write_strobe_or_wait, expansion_data_bus_oe_n, busy}, 9'h1FE);
		#5 rst_n = 1;
		foreach (rows[k]) begin
			{w, sp, a, es, ew, eh, d} = rows[k];
			word = d;
			run(w, 1'b0, sp, a, d);
			check(ns, es);
			check(nw, ew);
			check(nh, eh);
			check(av, a);
			check(w ? dv : rd_data, d);
		end
		// Ready held low stretches the strobe
		stall = 5'h09;
		word = 32'h0BAD_F00D;
		run(1'b0, 1'b0, 2'h3, 4'h3, 32'h0);
		check(nw >= 11 && nw <= 14, 1);
		check(rd_data, 32'h0BAD_F00D);
		stall = 0;
		// FIFO read outside space three, then inside it, then a write
		run(1'b0, 1'b1, 2'h1, 4'h2, 32'h0);
		check(nref, 1);
		check(ns + nw + nh, 0);
		run(1'b0, 1'b1, 2'h3, 4'h4, 32'h0);
		run(1'b1, 1'b1, 2'h0, 4'h9, 32'h5A5A_1234);
		check(nrv, 4);
		check(nw, 2);
		check(av, 4'h9);
		// One host write beat, last of its burst
		@(posedge host_clock_in) #5;
		{hw, hbe, host_chip_select_n, host_address_strobe, host_control_select, host_direction, host_burst_last} = 10'h2CD;
		@(posedge host_clock_in) #5;
		{host_chip_select_n, host_address_strobe} = 2'b10;
		for (i = 0; i < 40 && host_req_valid !== 1'b1; i++) @(negedge clock);
		check({host_req_valid, host_req_write, host_req_ctrl, host_req_be}, 7'h76);
		check(host_req_wdata, 32'hC0DE_0042);
		@(posedge clock) #5 host_resp_valid = 1;
		@(posedge clock) #5 host_resp_valid = 0;
		for (i = 0; i < 40 && {ready_line_oe_n, ready_line_out} !== 2'b00; i++) @(negedge host_clock_in);
		check({ready_line_oe_n, ready_line_out}, 0);
		for (i = 0; i < 40 && ready_line_oe_n !== 1'b1; i++) @(negedge host_clock_in);
		check(ready_line_oe_n, 1);
		hw = 0;
		finish_test;
	end
	// Watchdog
	initial begin
		#600000;
		errors++;
		finish_test;
	end
endmodule : testbench
`default_nettype wire
